// ==== rtl/aacc_ctrl.sv ====
// How it works
// - Idle state waits for an incoming ring, answers it, then waits for data set ready.
// - After answer and data set ready, wait for carrier, then pulse answer-back trigger.
// - On carrier detect move to the answer-back delay state.
// - After the delay drop line busy, then wait for carrier loss, long space, EOT.
// - Off-hook/terminal-ready is high to answer, low to disconnect.
// - A 10.24 s timer disconnects a wrong-number call.
// - A 1.28 s timer of continuous space disconnects the call.
// - The return-to-idle decode disconnects and goes idle on the next reader clock.
// - Ring lamp follows ring until answer, then stays lit until line ready.
// - Line-ready lamp is lit while the line is ready for data.
// - Received line data is synchronised to the clock before use.
// - Line busy while transmitter busy, or receiver busy in half duplex.
// - While the blinding input is low received line data is ignored.
// - Dedicated reset and power-on reset both clear the controller.
// - The reader clock is a 204.8 kHz square wave.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
module aacc_ctrl
	import aacc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       ring_in,
	input  wire logic       carrier_detect_in,
	input  wire logic       data_set_ready_in,
	input  wire logic       terminal_online_n,
	input  wire logic       rx_line_in,
	input  wire logic       rx_blind_n,
	input  wire logic       eot_received,
	input  wire logic       tx_busy,
	input  wire logic       rx_busy,
	input  wire logic       answer_ctrl_reset,
	input  wire logic       power_on_reset_n,
	output logic            off_hook_terminal_ready,
	output logic            answerback_trigger_n,
	output logic            ring_lamp_n,
	output logic            line_ready_lamp_n,
	output logic            line_busy_n,
	output logic            synced_rx_line_data,
	output logic            reader_clock
);

	aacc_tmr_if tif ();

	aacc_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n  (rst_n),
		.tif    (tif)
	);

	aacc_state_t state_q;
	aacc_state_t state_d;
	logic [1:0]  ctrl_q;
	logic [7:0]  abm_delay_q;
	logic [7:0]  reg_rdata_q;
	logic [7:0]  rdr_cnt_q;
	logic        rdr_clk_q;
	logic        rdr_tick;
	logic [1:0]  clr_sync_q;
	logic [1:0]  por_sync_q;
	logic        ctl_clear;
	logic [1:0]  rx_sync_q;
	logic        rx_data_q;
	logic        answered_q;
	logic        answered_d;
	logic        abm_trig_q;
	logic        ring_lamp_q;
	logic        line_rdy_q;
	logic        line_busy_q;
	logic        return_to_idle;
	logic        wrong_number;
	logic        long_space;

	// Reader clock: square wave from clk_sys, state moves on its rising edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdr_cnt_q <= 8'h0;
			rdr_clk_q <= 1'b0;
		end else if (rdr_cnt_q == RDR_HALF_LAST) begin
			rdr_cnt_q <= 8'h0;
			rdr_clk_q <= ~rdr_clk_q;
		end else begin
			rdr_cnt_q <= rdr_cnt_q + 8'h1;
		end
	end

	assign rdr_tick = (rdr_cnt_q == RDR_HALF_LAST) && !rdr_clk_q;

	// Both clear sources are synchronised; either one holds the controller cleared
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clr_sync_q <= 2'h3;
			por_sync_q <= 2'h0;
		end else begin
			clr_sync_q <= {clr_sync_q[0], answer_ctrl_reset};
			por_sync_q <= {por_sync_q[0], power_on_reset_n};
		end
	end

	assign ctl_clear = clr_sync_q[1] || !por_sync_q[1];

	// Received data: synchronise, then mask to mark while blinded
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_q <= 2'h3;
			rx_data_q <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[0], rx_line_in};
			rx_data_q <= rx_sync_q[1] || !rx_blind_n;
		end
	end

	// Register writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
			abm_delay_q <= ABM_DELAY_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL) begin
				ctrl_q <= reg_wdata[1:0];
			end else if (reg_addr == REG_ABM_DELAY) begin
				abm_delay_q <= reg_wdata;
			end
		end
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h0;
		end else if (!reg_rd) begin
			reg_rdata_q <= 8'h0;
		end else if (reg_addr == REG_CTRL) begin
			reg_rdata_q <= {6'h0, ctrl_q};
		end else if (reg_addr == REG_ABM_DELAY) begin
			reg_rdata_q <= abm_delay_q;
		end else if (reg_addr == REG_STATUS) begin
			reg_rdata_q <= {data_set_ready_in, carrier_detect_in, line_rdy_q,
				answered_q, state_q};
		end else begin
			reg_rdata_q <= 8'h0;
		end
	end

	// Disconnect conditions
	assign wrong_number = (state_q != CONNECTED_STATE) && answered_q
		&& (tif.state_ticks >= WRONG_NUMBER_TICKS);
	assign long_space = (state_q == CONNECTED_STATE)
		&& (tif.space_ticks >= LONG_SPACE_TICKS);
	assign tif.space_run = (state_q == CONNECTED_STATE) && !rx_data_q;

	always_comb begin
		return_to_idle = 1'b0;
		if (wrong_number) begin
			return_to_idle = 1'b1;
		end
		if (state_q == CONNECTED_STATE) begin
			if (!carrier_detect_in || long_space || eot_received) begin
				return_to_idle = 1'b1;
			end
		end
		if (answered_q && terminal_online_n) begin
			return_to_idle = 1'b1;
		end
	end

	// Call sequencing
	always_comb begin
		state_d = state_q;
		answered_d = answered_q;
		if (return_to_idle) begin
			state_d = IDLE_STATE;
			answered_d = 1'b0;
		end else begin
			case (state_q)
				IDLE_STATE: begin
					if (!answered_q) begin
						if (ring_in && !terminal_online_n && ctrl_q[CTRL_AUTO_ANSWER]) begin
							answered_d = 1'b1;
						end
					end else if (data_set_ready_in) begin
						state_d = WAIT_CARRIER_STATE;
					end
				end
				WAIT_CARRIER_STATE: begin
					if (carrier_detect_in) begin
						state_d = ANSWERBACK_DELAY_STATE;
					end
				end
				ANSWERBACK_DELAY_STATE: begin
					if (tif.state_ticks >= abm_delay_q) begin
						state_d = CONNECTED_STATE;
					end
				end
				CONNECTED_STATE: begin
					state_d = CONNECTED_STATE;
				end
				default: begin
					state_d = IDLE_STATE;
					answered_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= IDLE_STATE;
			answered_q <= 1'b0;
		end else if (ctl_clear) begin
			state_q <= IDLE_STATE;
			answered_q <= 1'b0;
		end else if (rdr_tick) begin
			state_q <= state_d;
			answered_q <= answered_d;
		end
	end

	// Timers restart whenever the state or the answer status changes
	assign tif.restart_state = ctl_clear
		|| (rdr_tick && ((state_d != state_q) || (answered_d != answered_q)));

	// Answer-back trigger: one reader-clock period low as carrier arrives
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			abm_trig_q <= 1'b0;
		end else if (ctl_clear) begin
			abm_trig_q <= 1'b0;
		end else if (rdr_tick) begin
			abm_trig_q <= (state_q == WAIT_CARRIER_STATE)
				&& (state_d == ANSWERBACK_DELAY_STATE);
		end
	end

	// Lamps and line busy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ring_lamp_q <= 1'b0;
			line_rdy_q <= 1'b0;
			line_busy_q <= 1'b0;
		end else begin
			ring_lamp_q <= answered_q ? (state_q != CONNECTED_STATE) : ring_in;
			line_rdy_q <= (state_q == CONNECTED_STATE);
			line_busy_q <= tx_busy || (rx_busy && ctrl_q[CTRL_HALF_DUPLEX])
				|| (state_q == WAIT_CARRIER_STATE)
				|| (state_q == ANSWERBACK_DELAY_STATE);
		end
	end

	assign reg_rdata = reg_rdata_q;
	assign off_hook_terminal_ready = answered_q;
	assign answerback_trigger_n = !abm_trig_q;
	assign ring_lamp_n = !ring_lamp_q;
	assign line_ready_lamp_n = !line_rdy_q;
	assign line_busy_n = !line_busy_q;
	assign synced_rx_line_data = rx_data_q;
	assign reader_clock = rdr_clk_q;

endmodule

// ==== rtl/aacc_pkg.sv ====
package aacc_pkg;

	// System clock
	localparam int unsigned CLK_HZ = 50_000_000;

	// Reader clock, in tenths of a hertz so that 204.8 kHz stays exact
	localparam int unsigned RDR_DHZ = 2_048_000;
	localparam int unsigned RDR_HALF_CYC = (CLK_HZ * 10) / (2 * RDR_DHZ);
	localparam logic [7:0] RDR_HALF_LAST = 8'(RDR_HALF_CYC - 1);

	// Slow timer tick
	localparam int unsigned TICK_MS = 80;
	localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

	// Delays in milliseconds and their tick counts
	localparam int unsigned WRONG_NUMBER_MS = 10240;
	localparam int unsigned LONG_SPACE_MS = 1280;
	localparam logic [7:0] WRONG_NUMBER_TICKS = 8'(WRONG_NUMBER_MS / TICK_MS);
	localparam logic [7:0] LONG_SPACE_TICKS = 8'(LONG_SPACE_MS / TICK_MS);

	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ABM_DELAY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// Control fields
	localparam int unsigned CTRL_AUTO_ANSWER = 0;
	localparam int unsigned CTRL_HALF_DUPLEX = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;

	// Answer-back delay in timer ticks
	localparam logic [7:0] ABM_DELAY_RESET = 8'h01;

	// Status fields: [3:0] state, 4 off-hook, 5 line ready, 6 carrier, 7 data set ready
	localparam int unsigned STAT_OFF_HOOK = 4;
	localparam int unsigned STAT_LINE_READY = 5;
	localparam int unsigned STAT_CARRIER = 6;
	localparam int unsigned STAT_DSR = 7;

	typedef enum logic [3:0] {
		IDLE_STATE = 4'b0001,
		WAIT_CARRIER_STATE = 4'b0010,
		ANSWERBACK_DELAY_STATE = 4'b0100,
		CONNECTED_STATE = 4'b1000
	} aacc_state_t;

endpackage

// ==== rtl/aacc_tmr_if.sv ====
`timescale 1ns/1ns
interface aacc_tmr_if;
	logic       tick;
	logic       restart_state;
	logic       space_run;
	logic [7:0] state_ticks;
	logic [7:0] space_ticks;

	modport ctrl (
		input  tick,
		input  state_ticks,
		input  space_ticks,
		output restart_state,
		output space_run
	);

	modport tmr (
		output tick,
		output state_ticks,
		output space_ticks,
		input  restart_state,
		input  space_run
	);
endinterface

// ==== rtl/aacc_timer.sv ====
`timescale 1ns/1ns
module aacc_timer
	import aacc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	aacc_tmr_if.tmr  tif
);

	logic [22:0] pre_q;
	logic        tick_q;
	logic [7:0]  state_ticks_q;
	logic [7:0]  space_ticks_q;

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction

	// Slow timer tick prescaler
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 23'h0;
			tick_q <= 1'b0;
		end else if (pre_q == 23'(TICK_CYCLES - 1)) begin
			pre_q <= 23'h0;
			tick_q <= 1'b1;
		end else begin
			pre_q <= pre_q + 23'h1;
			tick_q <= 1'b0;
		end
	end

	// Ticks spent in the present state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ticks_q <= 8'h0;
		end else if (tif.restart_state) begin
			state_ticks_q <= 8'h0;
		end else if (tick_q) begin
			state_ticks_q <= sat_inc(state_ticks_q);
		end
	end

	// Ticks of unbroken space on the line
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			space_ticks_q <= 8'h0;
		end else if (!tif.space_run || tif.restart_state) begin
			space_ticks_q <= 8'h0;
		end else if (tick_q) begin
			space_ticks_q <= sat_inc(space_ticks_q);
		end
	end

	assign tif.tick = tick_q;
	assign tif.state_ticks = state_ticks_q;
	assign tif.space_ticks = space_ticks_q;

endmodule

// ==== tb/aacc_ctrl_checker.sv ====
`timescale 1ns/1ns
module aacc_ctrl_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ring_in,
	input wire logic carrier_detect_in,
	input wire logic terminal_online_n,
	input wire logic rx_line_in,
	input wire logic rx_blind_n,
	input wire logic answer_ctrl_reset,
	input wire logic power_on_reset_n,
	input wire logic off_hook_terminal_ready,
	input wire logic answerback_trigger_n,
	input wire logic line_ready_lamp_n,
	input wire logic synced_rx_line_data,
	input wire logic reader_clock
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_trig_width:
		assert property ($fell(answerback_trigger_n) |=> !answerback_trigger_n[*8]
			##[200:260] answerback_trigger_n) else $error("trigger width");
	chk_trig_cause:
		assert property ($fell(answerback_trigger_n) |-> off_hook_terminal_ready
			&& carrier_detect_in) else $error("trigger without carrier");
	chk_reader_period:
		assert property ($rose(reader_clock) |-> ##244 $rose(reader_clock))
			else $error("reader clock period");
	chk_answer_cause:
		assert property ($rose(off_hook_terminal_ready) |-> !terminal_online_n
			&& $past(ring_in)) else $error("answer without ring");
	chk_ready_lamp:
		assert property ($fell(line_ready_lamp_n) |-> off_hook_terminal_ready
			&& carrier_detect_in) else $error("ready lamp early");
	chk_clear_hold:
		assert property ((answer_ctrl_reset || !power_on_reset_n)[*6]
			|-> !off_hook_terminal_ready) else $error("clear ignored");
	chk_offline_drop:
		assert property ($rose(terminal_online_n) |-> ##[0:300]
			!off_hook_terminal_ready) else $error("offline kept");
	chk_rx_sync:
		assert property ($stable({rx_line_in, rx_blind_n})[*3] |->
			synced_rx_line_data == (rx_line_in || !rx_blind_n)) else $error("rx data");
	cov_connect: cover property ($fell(line_ready_lamp_n));
	cov_trigger: cover property ($fell(answerback_trigger_n));
	cov_hangup: cover property ($fell(off_hook_terminal_ready));
endmodule
bind aacc_ctrl aacc_ctrl_checker i_chk (.clk_sys, .rst_n, .ring_in, .carrier_detect_in,
	.terminal_online_n, .rx_line_in, .rx_blind_n, .answer_ctrl_reset, .power_on_reset_n,
	.off_hook_terminal_ready, .answerback_trigger_n, .line_ready_lamp_n,
	.synced_rx_line_data, .reader_clock);

// ==== tb/aacc_modem.sv ====
`timescale 1ns/1ns
module aacc_modem (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic call,
	input wire logic dsr_ok,
	input wire logic cd_ok,
	input wire logic space,
	input wire logic oh,
	input wire logic trig_n,
	input wire logic aux2_remote_off_n,
	output logic     ring,
	output logic     dsr,
	output logic     cd,
	output logic     rx,
	output logic     abm_sent
);
	int held_q;
	// Ready 300 and carrier 900 cycles after going off hook
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			held_q <= 0;
			{ring, dsr, cd, rx} <= 4'h1;
		end else begin
			held_q <= oh ? held_q + 1 : 0;
			ring <= call && !oh;
			dsr <= dsr_ok && held_q > 32'h12c;
			cd <= cd_ok && held_q > 32'h384;
			rx <= !space;
		end
	end
	// Answer-back memory: remembers a trigger, held cleared while remote-off is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			abm_sent <= 1'b0;
		end else begin
			abm_sent <= aux2_remote_off_n && (abm_sent || !trig_n);
		end
	end
endmodule

// ==== tb/aacc_ctrl_tb.sv ====
`timescale 1ns/1ns
`define CK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end \
end
module aacc_ctrl_tb import aacc_pkg::*;;
	localparam int unsigned TK = 50;
	logic       clk_sys, rst_n, reg_wr, reg_rd, ring, cd, dsr, rx, oh, call;
	logic       terminal_online_n, rx_blind_n, eot_received, tx_busy, rx_busy;
	logic       answer_ctrl_reset, power_on_reset_n, dsr_ok, cd_ok, space;
	logic       lamp_n, rdy_n, busy_n, rx_q, trig_n, abm_sent, aux2_remote_off_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	int         failures, n_compared, n, cyc;
	aacc_ctrl #(.TICK_CYCLES(TK)) i_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .ring_in(ring), .carrier_detect_in(cd),
		.data_set_ready_in(dsr), .terminal_online_n, .rx_line_in(rx), .rx_blind_n,
		.eot_received, .tx_busy, .rx_busy, .answer_ctrl_reset, .power_on_reset_n,
		.off_hook_terminal_ready(oh), .answerback_trigger_n(trig_n), .ring_lamp_n(lamp_n),
		.line_ready_lamp_n(rdy_n), .line_busy_n(busy_n), .synced_rx_line_data(rx_q),
		.reader_clock());
	aacc_modem i_modem (.clk_sys, .rst_n, .call, .dsr_ok, .cd_ok, .space, .oh, .ring,
		.dsr, .cd, .rx, .trig_n, .aux2_remote_off_n, .abm_sent);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			close_out();
		end
	end
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CK("reg_rdata", e, reg_rdata)
	endtask
	task automatic wfor(input bit lamp, input logic v, input int lim);
		logic s;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			s = lamp ? rdy_n : oh;
		end while (s !== v && n < lim);
		`CK("wait", v, s)
	endtask
	task automatic idle;
		@(posedge clk_sys) {eot_received, space, terminal_online_n, dsr_ok, cd_ok} <= 5'h03;
		repeat (300) @(posedge clk_sys);
	endtask
	task automatic answer;
		@(posedge clk_sys) call <= 1'b1;
		wfor(1'b0, 1'b1, 1000);
		`CK("ring lamp", 1'b0, lamp_n)
		@(posedge clk_sys) call <= 1'b0;
		wfor(1'b1, 1'b0, 4000);
		`CK("ring lamp", 1'b1, lamp_n)
		rd(REG_STATUS, 8'hf8);
		`CK("line busy", 1'b1, busy_n)
		`CK("abm triggered", 1'b1, abm_sent)
		@(posedge clk_sys) aux2_remote_off_n <= 1'b0;
		@(posedge clk_sys) aux2_remote_off_n <= 1'b1;
	endtask
	task automatic t_regs;
		rd(REG_CTRL, 8'h01);
		rd(REG_ABM_DELAY, ABM_DELAY_RESET);
		wr(REG_STATUS, 8'hff);
		rd(REG_STATUS, 8'h01);
		rd(8'h0c, 8'h00);
		wr(REG_ABM_DELAY, 8'h02);
		rd(REG_ABM_DELAY, 8'h02);
		@(posedge clk_sys) {rx_blind_n, space} <= 2'b01;
		repeat (5) @(negedge clk_sys);
		`CK("blind rx", 1'b1, rx_q)
		@(posedge clk_sys) rx_blind_n <= 1'b1;
		repeat (5) @(negedge clk_sys);
		`CK("rx space", 1'b0, rx_q)
		@(posedge clk_sys) space <= 1'b0;
	endtask
	task automatic t_drop;
		for (int k = 0; k < 4; k++) begin
			answer();
			if (k == 0) begin
				@(posedge clk_sys) tx_busy <= 1'b1;
				repeat (3) @(negedge clk_sys);
				`CK("tx busy", 1'b0, busy_n)
				@(posedge clk_sys) {tx_busy, rx_busy} <= 2'b01;
				repeat (3) @(negedge clk_sys);
				`CK("rx busy full", 1'b1, busy_n)
				wr(REG_CTRL, 8'h03);
				repeat (3) @(negedge clk_sys);
				`CK("rx busy half", 1'b0, busy_n)
				wr(REG_CTRL, 8'h01);
			end
			@(posedge clk_sys);
			rx_busy <= 1'b0;
			case (k)
				0: eot_received <= 1'b1;
				1: cd_ok <= 1'b0;
				2: space <= 1'b1;
				default: terminal_online_n <= 1'b1;
			endcase
			wfor(1'b0, 1'b0, 17 * TK + 600);
			if (k == 2) `CK("space hold", 1'b1, n >= 15 * TK)
			idle();
		end
	endtask
	task automatic t_wrong;
		@(posedge clk_sys) {dsr_ok, cd_ok, call} <= 3'h1;
		wfor(1'b0, 1'b1, 1000);
		@(posedge clk_sys) call <= 1'b0;
		wfor(1'b0, 1'b0, 128 * TK + 600);
		`CK("wrong number hold", 1'b1, n >= 127 * TK - 8)
		idle();
	endtask
	task automatic t_refuse;
		wr(REG_CTRL, 8'h00);
		@(posedge clk_sys) call <= 1'b1;
		repeat (600) @(negedge clk_sys);
		`CK("disabled answer", 1'b0, oh)
		`CK("ring lamp", 1'b0, lamp_n)
		@(posedge clk_sys) terminal_online_n <= 1'b1;
		wr(REG_CTRL, 8'h01);
		repeat (600) @(negedge clk_sys);
		`CK("offline answer", 1'b0, oh)
		@(posedge clk_sys) call <= 1'b0;
		idle();
	endtask
	task automatic t_clear;
		for (int k = 0; k < 2; k++) begin
			answer();
			@(posedge clk_sys) {answer_ctrl_reset, power_on_reset_n} <= k[0] ? 2'h0 : 2'h3;
			repeat (8) @(negedge clk_sys);
			`CK("cleared hook", 1'b0, oh)
			`CK("cleared lamp", 1'b1, rdy_n)
			@(posedge clk_sys) {answer_ctrl_reset, power_on_reset_n} <= 2'h1;
			idle();
		end
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, call, space, eot_received, tx_busy, rx_busy} = 8'h00;
		{reg_addr, reg_wdata, terminal_online_n, answer_ctrl_reset} = 18'h0;
		{power_on_reset_n, rx_blind_n, dsr_ok, cd_ok, aux2_remote_off_n} = 5'h1f;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_regs();
		t_drop();
		t_wrong();
		t_refuse();
		t_clear();
		close_out();
	end
endmodule
